// ==== rtl/zch_top.sv ====
// Zero-command handler: text commands over a serial link, zero and tare state, APB registers.
// Assumes the weighing front end and the APB master run on clk; rxd and cts_n are asynchronous pins.
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module zch_top #(
	parameter int unsigned STAB_CYC  = zch_pkg::STAB_TIMEOUT_CYC,
	parameter logic [79:0] SERIAL_ID = "4242424242" // Arbitrary serial number.
) (
	input  wire logic               clk,
	input  wire logic               resetn,
	input  wire logic               ce,
	input  wire logic [7:0]         paddr,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [31:0]        pwdata,
	input  wire logic [3:0]         pstrb,
	output logic [31:0]             prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire logic               rxd,
	output logic                    txd,
	input  wire logic               cts_n,
	output logic                    dtr_n,
	input  wire zch_pkg::zch_meas_t meas
);
	import zch_pkg::*;

	typedef struct packed {
		zch_mode_t          st;
		logic [1:0]         clen;
		logic [7:0]         c0;
		logic [7:0]         c1;
		logic [31:0]        tmo;
		zch_reply_t         rep;
		zch_reply_t         last;
		logic [4:0]         idx;
		logic               txact;
		logic               txd;
		logic [15:0]        bcnt;
		logic [3:0]         bitn;
		logic [9:0]         sh;
		logic               cts1;
		logic               cts2;
		logic [4:0]         ctrl;
		logic [15:0]        div;
		logic signed [23:0] zlo;
		logic signed [23:0] zhi;
		logic signed [23:0] tare;
		logic signed [23:0] zero;
		logic signed [23:0] pwr;
		logic               pwr_ok;
		logic               ld;
		logic [31:0]        prd;
	} zch_state_t;

	typedef struct packed {
		logic [4:0]   len;
		logic [159:0] txt;
	} zch_msg_t;

	localparam zch_state_t ST_RST = '{st: M_SEND, rep: R_ID, last: R_ID, txd: 1'b1, cts1: 1'b1, cts2: 1'b1,
		ctrl: CTRL_RST, div: BAUD_DIV_RST, zlo: ZLO_RST, zhi: ZHI_RST, default: '0};

	zch_state_t         q;
	zch_state_t         d;
	zch_link_cfg_t      cfg;
	zch_rx_byte_t       rxb;
	zch_msg_t           msg;
	logic signed [23:0] rel;
	logic signed [23:0] gross;
	logic signed [23:0] net;
	logic               hi;
	logic               lo;
	logic               approved;
	logic               hs;
	logic               lf_in;
	logic               is_z;
	logic               is_imm;
	logic               unm;
	logic               wr;
	logic [31:0]        rd_w;
	logic [4:0]         k;
	logic [7:0]         tb;
	logic               send;
	logic               zdo;
	zch_reply_t         nrep;
	logic               hasp;
	logic               pb;
	logic [10:0]        fr;
	logic [3:0]         nb;

	// Reply text, right aligned; the last byte sent sits in the low bits.
	function automatic zch_msg_t reply_text(input zch_reply_t r, input logic [79:0] sid);
		zch_msg_t m;
		m = '{5'd4, 160'({"ES", 8'h0d, 8'h0a})};
		unique case (r)
			R_ID:  m = '{5'd19, 160'({CH_I, CH_FOUR, " A \"", sid, "\"", CH_CR, CH_LF})};
			R_ZA:  m = '{5'd5, 160'({CH_Z, " A", CH_CR, CH_LF})};
			R_ZNX: m = '{5'd5, 160'({CH_Z, " I", CH_CR, CH_LF})};
			R_ZP:  m = '{5'd5, 160'({CH_Z, " +", CH_CR, CH_LF})};
			R_ZM:  m = '{5'd5, 160'({CH_Z, " -", CH_CR, CH_LF})};
			R_ZIS: m = '{5'd6, 160'({CH_Z, CH_I, " S", CH_CR, CH_LF})};
			R_ZID: m = '{5'd6, 160'({CH_Z, CH_I, " D", CH_CR, CH_LF})};
			R_ZII: m = '{5'd6, 160'({CH_Z, CH_I, " I", CH_CR, CH_LF})};
			R_ZIP: m = '{5'd6, 160'({CH_Z, CH_I, " +", CH_CR, CH_LF})};
			R_ZIM: m = '{5'd6, 160'({CH_Z, CH_I, " -", CH_CR, CH_LF})};
			R_ES:  m = '{5'd4, 160'({"ES", CH_CR, CH_LF})};
		endcase
		return m;
	endfunction : reply_text

	// Sign extension of a 24-bit value to the bus width.
	function automatic logic [31:0] sx(input logic [23:0] v);
		return {{8{v[23]}}, v};
	endfunction : sx

	// Byte-lane merge of a write into an old register value.
	function automatic logic [31:0] wm(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
		logic [31:0] m;
		m = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
		return (old & ~m) | (nw & m);
	endfunction : wm

	// Link settings and weight arithmetic; the power-on point never moves.
	assign approved = q.ctrl[CTRL_APPROVED];
	assign hs       = q.ctrl[CTRL_HS];
	assign cfg      = '{eight: q.ctrl[CTRL_EIGHT], par: zch_par_t'(q.ctrl[CTRL_PAR_LSB +: 2]), div: q.div};
	assign rel      = meas.weight - q.pwr;
	assign gross    = rel - q.zero;
	assign net      = gross - q.tare;
	assign hi       = rel > q.zhi;
	assign lo       = rel < q.zlo;

	// Command line decode.
	assign lf_in = (q.st == M_IDLE) && rxb.valid && !rxb.perr && (rxb.data == CH_LF);
	assign is_z  = (q.clen == 2'd1) && (q.c0 == CH_Z);
	assign is_imm = (q.clen == 2'd2) && (q.c0 == CH_Z) && (q.c1 == CH_I);

	// Bus decode; read data is captured in every selected cycle and ready waits for that capture.
	assign pready  = ce && psel && penable && q.ld;
	assign wr      = pready && pwrite && !unm;
	assign pslverr = pready && unm;
	assign prdata  = q.prd;

	always_comb
	begin
		unm  = 1'b0;
		rd_w = 32'h0000_0000;
		unique case (paddr)
			OFF_CTRL:   rd_w = {27'h0, q.ctrl};
			OFF_BAUD:   rd_w = {16'h0, q.div};
			OFF_ZLO:    rd_w = sx(q.zlo);
			OFF_ZHI:    rd_w = sx(q.zhi);
			OFF_TARE:   rd_w = sx(q.tare);
			OFF_ZERO:   rd_w = sx(q.zero);
			OFF_GROSS:  rd_w = sx(gross);
			OFF_NET:    rd_w = sx(net);
			OFF_STATUS: rd_w = {26'h0, q.last, q.txact, q.st == M_WAIT};
			default:    unm = 1'b1;
		endcase
	end

	// Transmit byte and its frame, LSB first, start bit in bit 0.
	assign msg  = reply_text(q.rep, SERIAL_ID);
	assign k    = msg.len - 5'd1 - q.idx;
	assign tb   = msg.txt[{k, 3'b000} +: 8];
	assign hasp = (cfg.par == PAR_EVEN) || (cfg.par == PAR_ODD);
	assign pb   = (^(cfg.eight ? tb : {1'b0, tb[6:0]})) ^ (cfg.par == PAR_ODD);

	always_comb
	begin
		if (cfg.eight)
		begin
			fr = {1'b1, hasp ? pb : 1'b1, tb, 1'b0};
			nb = hasp ? 4'd11 : 4'd10;
		end
		else
		begin
			fr = {2'b11, hasp ? pb : 1'b1, tb[6:0], 1'b0};
			nb = hasp ? 4'd10 : 4'd9;
		end
	end

	// Next state: bus writes, command sequencing, zeroing and the transmitter.
	always_comb
	begin
		d      = q;
		send   = 1'b0;
		zdo    = 1'b0;
		nrep   = R_ES;
		d.cts1 = cts_n;
		d.cts2 = q.cts1;
		d.ld   = psel && !pready;
		if (psel)
			d.prd = rd_w;
		if (!q.pwr_ok)
		begin
			d.pwr    = meas.weight;
			d.pwr_ok = 1'b1;
		end
		if (wr)
		begin
			unique case (paddr)
				OFF_CTRL: d.ctrl = 5'(wm({27'h0, q.ctrl}, pwdata, pstrb));
				OFF_BAUD: d.div  = 16'(wm({16'h0, q.div}, pwdata, pstrb));
				OFF_ZLO:  d.zlo  = 24'(wm(sx(q.zlo), pwdata, pstrb));
				OFF_ZHI:  d.zhi  = 24'(wm(sx(q.zhi), pwdata, pstrb));
				OFF_TARE: d.tare = 24'(wm(sx(q.tare), pwdata, pstrb));
				default:  d.ctrl = q.ctrl;
			endcase
		end
		// Bit timing of a character in flight.
		if (q.txact)
		begin
			if (q.bcnt != 16'h0000)
				d.bcnt = q.bcnt - 16'h0001;
			else if (q.bitn == 4'd0)
				d.txact = 1'b0;
			else
			begin
				d.txd  = q.sh[0];
				d.sh   = {1'b1, q.sh[9:1]};
				d.bitn = q.bitn - 4'd1;
				d.bcnt = q.div - 16'h0001;
			end
		end
		unique case (q.st)
			M_IDLE:
			begin
				if (rxb.valid && !rxb.perr)
				begin
					if (rxb.data == CH_LF)
					begin
						d.clen = 2'd0;
						send   = 1'b1;
						if (is_z)
						begin
							if (meas.busy)
								nrep = R_ZNX;
							else
							begin
								send   = 1'b0;
								d.st   = M_WAIT;
								d.tmo  = STAB_CYC - 1;
							end
						end
						else if (is_imm)
						begin
							if (approved)
								nrep = R_ES;
							else if (meas.busy)
								nrep = R_ZII;
							else if (hi)
								nrep = R_ZIP;
							else if (lo)
								nrep = R_ZIM;
							else
							begin
								zdo  = 1'b1;
								nrep = meas.stable ? R_ZIS : R_ZID;
							end
						end
					end
					else if (rxb.data != CH_CR && q.clen != 2'd3)
					begin
						if (q.clen == 2'd0)
							d.c0 = rxb.data;
						else if (q.clen == 2'd1)
							d.c1 = rxb.data;
						d.clen = q.clen + 2'd1;
					end
				end
			end
			M_WAIT:
			begin
				if (meas.stable)
				begin
					send = 1'b1;
					if (hi)
						nrep = R_ZP;
					else if (lo)
						nrep = R_ZM;
					else
					begin
						zdo  = 1'b1;
						nrep = R_ZA;
					end
				end
				else if (q.tmo == 32'h0000_0000)
				begin
					send = 1'b1;
					nrep = R_ZNX;
				end
				else
					d.tmo = q.tmo - 32'h0000_0001;
			end
			M_SEND:
			begin
				if (!q.txact && q.idx == msg.len)
					d.st = M_IDLE;
				else if (!q.txact && (!hs || !q.cts2))
				begin
					d.txd   = fr[0];
					d.sh    = fr[10:1];
					d.bitn  = nb - 4'd1;
					d.bcnt  = q.div - 16'h0001;
					d.txact = 1'b1;
					d.idx   = q.idx + 5'd1;
				end
			end
			default: d.st = M_IDLE;
		endcase
		if (send)
		begin
			d.st   = M_SEND;
			d.rep  = nrep;
			d.last = nrep;
			d.idx  = 5'd0;
		end
		// A zeroing takes the present weight as zero and wins over a tare write in the same cycle.
		if (zdo)
		begin
			d.zero = rel;
			d.tare = 24'sh000000;
		end
	end

	// State register, frozen while the clock enable is low; power-on sends the identification.
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			q <= ST_RST;
		else if (ce)
			q <= d;
	end

	assign txd   = q.txd;
	assign dtr_n = hs ? (q.st != M_IDLE) : 1'b0;

	zch_rx u_rx (
		.clk    (clk),
		.resetn (resetn),
		.ce     (ce),
		.rxd    (rxd),
		.cfg    (cfg),
		.rx_out (rxb)
	);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence s_stab_ok;
		ce && q.st == M_WAIT && meas.stable && !hi && !lo;
	endsequence

	sequence s_imm_cmd;
		ce && lf_in && is_imm;
	endsequence

	a_zero_success:
	assert property (s_stab_ok |=> q.zero == $past(rel) && q.tare == 24'sh000000 && q.rep == R_ZA)
		else $error("Stable zero did not set zero and clear tare.");

	a_zero_busy:
	assert property (ce && lf_in && is_z && meas.busy |=> q.st == M_SEND && q.rep == R_ZNX)
		else $error("Zero while busy not refused.");

	a_stab_timeout:
	assert property (ce && q.st == M_WAIT && !meas.stable && q.tmo == 32'h0 |=> q.rep == R_ZNX && $stable(q.zero))
		else $error("Stability timeout not reported.");

	a_range_upper:
	assert property (ce && q.st == M_WAIT && meas.stable && hi |=> q.rep == R_ZP && $stable(q.zero))
		else $error("Upper range zero not refused.");

	a_tare_cleared:
	assert property (ce && zdo |=> q.tare == 24'sh000000 ##1 q.st == M_SEND || q.st == M_IDLE)
		else $error("Tare kept after zeroing.");

	a_pwr_point:
	assert property (q.pwr_ok |=> $stable(q.pwr))
		else $error("Power-on zero point moved.");

	a_gross_rel:
	assert property (ce && zdo |=> gross == 24'(meas.weight - $past(meas.weight)))
		else $error("Gross not relative to new zero.");

	a_imm_flag:
	assert property (s_imm_cmd ##0 (!approved && !meas.busy && !hi && !lo)
		|=> q.rep == ($past(meas.stable) ? R_ZIS : R_ZID))
		else $error("Immediate zero stability flag wrong.");

	a_approved_no:
	assert property (s_imm_cmd ##0 approved |=> q.rep == R_ES && $stable(q.zero))
		else $error("Approved instrument executed immediate zero.");

	a_ident_first:
	assert property (!q.pwr_ok |-> q.st == M_SEND && q.rep == R_ID && q.idx == 5'd0)
		else $error("Identification not first after power-on.");

	a_hs_none:
	assert property (!hs |-> !dtr_n)
		else $error("Flow control active with handshake off.");

	a_imm_busy:
	assert property (s_imm_cmd ##0 (!approved && meas.busy) |=> q.rep == R_ZII && $stable(q.zero))
		else $error("Immediate zero while busy not refused.");

endmodule : zch_top
`default_nettype wire

// ==== shared/zch_pkg.sv ====
// Constants, register map and carrier types of the zero-command handler.
// Assumes a 40 MHz clock and APB access with 32-bit data, one aligned word per register.
package zch_pkg;

	// Clock rate and stability wait.
	localparam int unsigned CLK_KHZ          = 40000;
	localparam int unsigned STAB_TIMEOUT_MS  = 2000;
	localparam int unsigned STAB_TIMEOUT_CYC = STAB_TIMEOUT_MS * CLK_KHZ;
	localparam int unsigned BAUD_DEFAULT     = 9600;
	localparam logic [15:0] BAUD_DIV_RST     = 16'(CLK_KHZ * 1000 / BAUD_DEFAULT);

	// Register byte offsets.
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_BAUD   = 8'h04;
	localparam logic [7:0] OFF_ZLO    = 8'h08;
	localparam logic [7:0] OFF_ZHI    = 8'h0c;
	localparam logic [7:0] OFF_TARE   = 8'h10;
	localparam logic [7:0] OFF_ZERO   = 8'h14;
	localparam logic [7:0] OFF_GROSS  = 8'h18;
	localparam logic [7:0] OFF_NET    = 8'h1c;
	localparam logic [7:0] OFF_STATUS = 8'h20;

	// Control field positions and reset values.
	localparam int unsigned CTRL_APPROVED = 0;
	localparam int unsigned CTRL_HS       = 1;
	localparam int unsigned CTRL_EIGHT    = 2;
	localparam int unsigned CTRL_PAR_LSB  = 3;
	localparam logic [4:0]  CTRL_RST      = 5'h04;
	localparam logic [23:0] ZLO_RST       = 24'hffe000;
	localparam logic [23:0] ZHI_RST       = 24'h002000;

	// Characters of the text protocol.
	localparam logic [7:0] CH_Z    = 8'h5a;
	localparam logic [7:0] CH_I    = 8'h49;
	localparam logic [7:0] CH_FOUR = 8'h34;
	localparam logic [7:0] CH_CR   = 8'h0d;
	localparam logic [7:0] CH_LF   = 8'h0a;

	typedef enum logic [1:0] {PAR_NONE, PAR_EVEN, PAR_ODD} zch_par_t;
	typedef enum logic [1:0] {M_IDLE, M_WAIT, M_SEND} zch_mode_t;
	typedef enum logic [3:0] {R_ID, R_ZA, R_ZNX, R_ZP, R_ZM, R_ZIS, R_ZID, R_ZII, R_ZIP, R_ZIM, R_ES} zch_reply_t;

	// Serial framing settings shared by receiver and transmitter.
	typedef struct packed {
		logic     eight;
		zch_par_t par;
		logic [15:0] div;
	} zch_link_cfg_t;

	// One received character.
	typedef struct packed {
		logic       valid;
		logic       perr;
		logic [7:0] data;
	} zch_rx_byte_t;

	// Weighing front end as seen by the handler.
	typedef struct packed {
		logic signed [23:0] weight;
		logic               stable;
		logic               busy;
	} zch_meas_t;

endpackage : zch_pkg

// ==== rtl/zch_rx.sv ====
// Serial character receiver of the zero-command handler.
// Assumes rxd is an asynchronous pin; framing comes from the same clock domain.
`timescale 1ns/1ps
`default_nettype none
module zch_rx (
	input  wire logic                   clk,
	input  wire logic                   resetn,
	input  wire logic                   ce,
	input  wire logic                   rxd,
	input  wire zch_pkg::zch_link_cfg_t cfg,
	output var  zch_pkg::zch_rx_byte_t  rx_out
);
	import zch_pkg::*;

	typedef struct packed {
		logic         s1;
		logic         s2;
		logic         busy;
		logic [15:0]  bcnt;
		logic [3:0]   bitn;
		logic [9:0]   sh;
		zch_rx_byte_t out;
	} zch_rx_state_t;

	localparam zch_rx_state_t RX_RST = '{s1: 1'b1, s2: 1'b1, default: '0};

	zch_rx_state_t q;
	zch_rx_state_t d;
	logic          hasp;
	logic [3:0]    nbits;
	logic [9:0]    shn;
	logic [9:0]    al;
	logic [7:0]    d8;
	logic          pb;

	// Frame length after the start bit follows the configured format.
	assign hasp  = (cfg.par == PAR_EVEN) || (cfg.par == PAR_ODD);
	assign nbits = (cfg.eight ? 4'd9 : 4'd8) + {3'b000, hasp};
	assign shn   = {q.s2, q.sh[9:1]};
	assign al    = shn >> (4'd10 - nbits);
	assign d8    = cfg.eight ? al[7:0] : {1'b0, al[6:0]};
	assign pb    = cfg.eight ? al[8] : al[7];

	// Synchronise the pin, find the start bit, sample each bit at its middle.
	always_comb
	begin
		d           = q;
		d.s1        = rxd;
		d.s2        = q.s1;
		d.out.valid = 1'b0;
		if (!q.busy)
		begin
			if (!q.s2)
			begin
				d.busy = 1'b1;
				d.bcnt = cfg.div >> 1;
				d.bitn = 4'd0;
			end
		end
		else if (q.bcnt != 16'h0000)
			d.bcnt = q.bcnt - 16'h0001;
		else if (q.bitn == 4'd0)
		begin
			d.busy = !q.s2;
			d.bitn = 4'd1;
			d.bcnt = cfg.div - 16'h0001;
		end
		else
		begin
			d.sh   = shn;
			d.bcnt = cfg.div - 16'h0001;
			d.bitn = q.bitn + 4'd1;
			if (q.bitn == nbits)
			begin
				d.busy         = 1'b0;
				d.out.valid    = al[nbits - 4'd1]; // A missing stop bit drops the character.
				d.out.data     = d8;
				d.out.perr     = hasp && (pb != ((^d8) ^ (cfg.par == PAR_ODD)));
			end
		end
	end

	// State register, frozen while the clock enable is low.
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			q <= RX_RST;
		else if (ce)
			q <= d;
	end

	assign rx_out = q.out;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	a_seven_bit_data:
	assert property (!cfg.eight && q.out.valid |-> !q.out.data[7])
		else $error("Seven-bit character carries bit 7.");

	a_no_parity_err:
	assert property (ce && q.busy && q.bitn == nbits && q.bcnt == 16'h0000 && !hasp |=> !q.out.perr)
		else $error("Parity error flagged without parity.");

endmodule : zch_rx
`default_nettype wire

// ==== verif/zch_host_model.sv ====
// Host computer model on the far side of the serial link.
// Assumes the bench sets div, eight and par to match the handler's link settings.
`timescale 1ns/1ps
`default_nettype none
module zch_host_model (
	input  wire logic clk,
	input  wire logic txd,
	output logic      rxd
);
	int unsigned div   = 8;
	logic        eight = 1'b1;
	logic [1:0]  par   = 2'h0;
	logic [7:0]  rx_q[$];

	// Sends one character: start, data LSB first, optional parity, stop.
	task automatic send_byte(input logic [7:0] b);
		logic [7:0] d;
		d = eight ? b : {1'b0, b[6:0]};
		rxd <= 1'b0;
		repeat (div) @(posedge clk);
		for (int i = 0; i < (eight ? 8 : 7); i++)
		begin
			rxd <= d[i];
			repeat (div) @(posedge clk);
		end
		if (par == 2'h1 || par == 2'h2)
		begin
			rxd <= (par == 2'h2) ? ~^d : ^d;
			repeat (div) @(posedge clk);
		end
		rxd <= 1'b1;
		repeat (div) @(posedge clk);
	endtask : send_byte

	// Sends a command line closed by carriage return and line feed.
	task automatic send_line(input string s);
		foreach (s[i])
			send_byte(s[i]);
		send_byte(8'h0d);
		send_byte(8'h0a);
	endtask : send_line

	// Collects reply characters, sampled near the middle of each bit.
	initial
	begin
		rxd = 1'b1;
		forever
		begin
			logic [7:0] d;
			d = 8'h00;
			@(posedge clk iff txd === 1'b0);
			repeat (div / 2) @(posedge clk);
			for (int i = 0; i < (eight ? 8 : 7); i++)
			begin
				repeat (div) @(posedge clk);
				d[i] = txd;
			end
			repeat ((par == 2'h1 || par == 2'h2) ? 2 * div : div) @(posedge clk);
			rx_q.push_back(d);
		end
	end
endmodule : zch_host_model
`default_nettype wire

// ==== verif/tb_zero_command_handler.sv ====
// Self-checking bench of the zero-command handler.
// Assumes the host model and the design top; the stability wait is shortened to 200 cycles.
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) \
	begin total_checks++; if ((got) !== (exp)) begin errors++; \
	$display("mismatch %s expected %h seen %h", what, exp, got); end end
module tb_zero_command_handler;
	import zch_pkg::*;
	logic        clk     = 1'b0;
	logic        resetn  = 1'b0;
	logic [7:0]  paddr   = 8'h00;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [31:0] pwdata  = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        rxd;
	logic        txd;
	logic        cts_n   = 1'b1;
	logic        dtr_n;
	zch_meas_t   meas    = '{24'h3e8, 1'b0, 1'b0};
	int          errors  = 0;
	int          total_checks = 0;
	int          cycles  = 0;

	// Clock of 25 ns period.
	always #12.5 clk = ~clk;

	zch_top #(.STAB_CYC(200)) dut (
		.clk     (clk),
		.resetn  (resetn),
		.ce      (1'b1),
		.paddr   (paddr),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.pwdata  (pwdata),
		.pstrb   (4'hf),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.rxd     (rxd),
		.txd     (txd),
		.cts_n   (cts_n),
		.dtr_n   (dtr_n),
		.meas    (meas)
	);

	zch_host_model host (.clk(clk), .txd(txd), .rxd(rxd));

	// Prints the counts and the verdict, then stops.
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : results

	// Cuts a hung run short.
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			errors++;
			results();
		end
	end

	// One APB transfer, held until pready, then one idle cycle; only the run timeout ends the wait.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] r, output logic e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask : wr

	task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] x);
		logic [31:0] r;
		logic        e;
		apb(1'b0, a, 32'h0, r, e);
		`CHK(nm, x, r)
	endtask : rd

	task automatic put(input logic [23:0] w, input logic st, input logic bz);
		meas <= '{w, st, bz};
	endtask : put

	// Waits for a whole reply line and compares it with the text plus CR LF.
	task automatic expect_reply(input string rep, input string nm);
		logic [63:0] x;
		logic [63:0] g;
		int          n;
		x = 64'h0;
		g = 64'h0;
		n = 0;
		while (host.rx_q.size() < rep.len() + 2 && n < 4000)
		begin
			n++;
			@(posedge clk);
		end
		foreach (rep[i])
			x = {x[55:0], rep[i]};
		x = {x[47:0], 16'h0d0a};
		foreach (host.rx_q[i])
			g = {g[55:0], host.rx_q[i]};
		`CHK(nm, x, g)
		repeat (20) @(posedge clk);
	endtask : expect_reply

	task automatic cmd(input string s, input string rep, input string nm);
		host.rx_q.delete();
		host.send_line(s);
		expect_reply(rep, nm);
	endtask : cmd

	// Sends a line that must draw no answer within 300 cycles.
	task automatic quiet(input string s, input string nm);
		host.rx_q.delete();
		host.send_line(s);
		repeat (300) @(posedge clk);
		`CHK(nm, 0, host.rx_q.size())
	endtask : quiet

	task automatic done(input string nm);
		$display("test %s done", nm);
	endtask : done

	task automatic t_reset();
		logic [31:0] r;
		logic        e;
		int          n;
		int          z;
		// The identification starts at the first edge after release, so the status is captured one edge later.
		@(posedge clk);
		apb(1'b0, OFF_STATUS, 32'h0, r, e);
		`CHK("status busy", 6'h02, r[5:0])
		rd("ctrl", OFF_CTRL, 32'h4);
		rd("baud", OFF_BAUD, 32'h1046);
		wr(OFF_BAUD, 32'h8);
		rd("zlo", OFF_ZLO, 32'hffffe000);
		rd("zhi", OFF_ZHI, 32'h2000);
		apb(1'b1, 8'h24, 32'h1, r, e);
		`CHK("unmapped error", 1'b1, e)
		rd("unmapped read", 8'h24, 32'h0);
		`CHK("dtr idle", 1'b0, dtr_n)
		// The transmitter idles for one cycle between bytes, so two idle reads in a row mark the end.
		n = 0;
		z = 0;
		while (z < 2 && n < 3000)
		begin
			apb(1'b0, OFF_STATUS, 32'h0, r, e);
			z = r[1] ? 0 : z + 1;
			n++;
		end
		`CHK("ident code", 6'h00, r[5:0])
		repeat (200) @(posedge clk);
		done("reset");
	endtask : t_reset

	task automatic t_imm();
		wr(OFF_TARE, 32'h5);
		put(24'h44c, 1'b0, 1'b0);
		cmd("ZI", "ZI D", "dynamic reply");
		rd("zero", OFF_ZERO, 32'h64);
		rd("tare", OFF_TARE, 32'h0);
		rd("gross", OFF_GROSS, 32'h0);
		rd("net", OFF_NET, 32'h0);
		rd("zlo kept", OFF_ZLO, 32'hffffe000);
		put(24'h47e, 1'b0, 1'b0);
		rd("gross moved", OFF_GROSS, 32'h32);
		wr(OFF_TARE, 32'h14);
		rd("net moved", OFF_NET, 32'h1e);
		put(24'h4b0, 1'b1, 1'b0);
		cmd("ZI", "ZI S", "stable reply");
		rd("zero", OFF_ZERO, 32'hc8);
		done("immediate");
	endtask : t_imm

	task automatic t_z();
		wr(OFF_TARE, 32'h7);
		put(24'h514, 1'b1, 1'b0);
		cmd("Z", "Z A", "zero reply");
		rd("zero", OFF_ZERO, 32'h12c);
		rd("tare", OFF_TARE, 32'h0);
		rd("net", OFF_NET, 32'h0);
		put(24'h514, 1'b1, 1'b1);
		cmd("Z", "Z I", "busy reply");
		cmd("ZI", "ZI I", "busy immediate");
		put(24'h514, 1'b0, 1'b0);
		cmd("Z", "Z I", "timeout reply");
		rd("zero kept", OFF_ZERO, 32'h12c);
		done("stable zero");
	endtask : t_z

	task automatic t_range();
		put(24'h23e9, 1'b1, 1'b0);
		cmd("Z", "Z +", "upper");
		cmd("ZI", "ZI +", "upper immediate");
		put(24'hffe3e7, 1'b1, 1'b0);
		cmd("Z", "Z -", "lower");
		cmd("ZI", "ZI -", "lower immediate");
		rd("zero kept", OFF_ZERO, 32'h12c);
		put(24'h23e8, 1'b1, 1'b0);
		cmd("ZI", "ZI S", "upper edge");
		rd("zero", OFF_ZERO, 32'h2000);
		put(24'hffe3e8, 1'b1, 1'b0);
		cmd("Z", "Z A", "lower edge");
		rd("zero", OFF_ZERO, 32'hffffe000);
		done("range");
	endtask : t_range

	task automatic t_link();
		string s;
		s = "ZI";
		s[0] = 8'hda;
		wr(OFF_CTRL, 32'h5);
		put(24'h3e8, 1'b1, 1'b0);
		cmd("ZI", "ES", "approved");
		rd("zero kept", OFF_ZERO, 32'hffffe000);
		cmd("Z", "Z A", "approved zero");
		wr(OFF_CTRL, 32'h6);
		`CHK("dtr idle", 1'b0, dtr_n)
		put(24'h41a, 1'b1, 1'b0);
		quiet("ZI", "held by cts");
		`CHK("dtr busy", 1'b1, dtr_n)
		cts_n <= 1'b0;
		expect_reply("ZI S", "released");
		cts_n <= 1'b1;
		wr(OFF_CTRL, 32'h8);
		host.eight = 1'b0;
		host.par = 2'h1;
		put(24'h3fc, 1'b1, 1'b0);
		cmd(s, "ZI S", "seven even");
		rd("zero", OFF_ZERO, 32'h14);
		host.par = 2'h2;
		quiet("ZI", "parity mismatch");
		wr(OFF_CTRL, 32'h10);
		cmd("ZI", "ZI S", "seven odd");
		wr(OFF_CTRL, 32'h4);
		host.eight = 1'b1;
		host.par = 2'h0;
		cmd(s, "ES", "high code");
		done("link");
	endtask : t_link

	// Main sequence: reset, then each scenario in turn.
	initial
	begin
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		t_reset();
		t_imm();
		t_z();
		t_range();
		t_link();
		results();
	end
endmodule : tb_zero_command_handler
`default_nettype wire
